// ==== hdl/ssp_regs.svh ====
// register offsets, reset values and counts of the synchronous serial port
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
`define SSP_OFS_RX_CTRL 5'h00
`define SSP_OFS_TX_CTRL 5'h04
`define SSP_OFS_BAUD_DIV 5'h08
`define SSP_OFS_TX_HOLD 5'h0C
`define SSP_OFS_RX_DATA 5'h10
`define SSP_OFS_INT_EN 5'h14
`define SSP_OFS_INT_FLAGS 5'h18
`define SSP_RX_CTRL_RESET 8'h00
`define SSP_TX_CTRL_RESET 8'h02
`define SSP_BAUD_DIV_RESET 8'h00
`define SSP_TX_HOLD_RESET 8'h00
`define SSP_INT_EN_RESET 8'h00
`define SSP_BITS_EIGHT 4'h8
`define SSP_BITS_NINE 4'h9
`define SSP_LOW_SPEED_SHIFT 4'h2
`define SSP_FIFO_DEPTH 2'h2
`define SSP_LOW_BYTE_LANE 2'h0
`endif

// ==== hdl/ssp_pkg.sv ====
// types and helper functions of the synchronous serial port
package ssp_pkg;
`include "ssp_regs.svh"

   typedef enum logic [1:0] {SSP_IDLE, SSP_TX, SSP_RX} ssp_mode_t;

   typedef struct packed {
      logic port_enable;
      logic receive_nine_bit;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic address_detect_enable;
      logic framing_unused;
      logic overrun_flag;
      logic receive_ninth_bit_value;
   } ssp_rx_ctrl_t;

   typedef struct packed {
      logic clock_source_master;
      logic transmit_nine_bit;
      logic transmit_enable;
      logic sync_mode;
      logic unused;
      logic baud_high_speed;
      logic shifter_empty_status;
      logic transmit_ninth_bit_value;
   } ssp_tx_ctrl_t;

   typedef struct packed {
      logic [1:0] other_hi;
      logic receive;
      logic transmit;
      logic [3:0] other_lo;
   } ssp_int_bits_t;

   function automatic logic [3:0] ssp_char_bits(input logic nine);
      return nine ? `SSP_BITS_NINE : `SSP_BITS_EIGHT;
   endfunction : ssp_char_bits

   function automatic logic [10:0] ssp_half_len(input logic [7:0] div, input logic fast);
      logic [10:0] base;
      base = {3'h0, div} + 11'h001;
      return fast ? base : (base << `SSP_LOW_SPEED_SHIFT);
   endfunction : ssp_half_len
endpackage : ssp_pkg

// ==== hdl/ssp_top.sv ====
// synchronous half-duplex serial port, master or slave, with avalon-mm registers
//
// Functional notes
// RULE_01: master receive turns data pin driver off
// RULE_02: either receive enable starts reception
// RULE_03: single receive: one character, then self-clears
// RULE_04: continuous receive runs; clearing aborts character
// RULE_05: both set: single clears, continuous continues
// RULE_06: sample data on trailing clock edge
// RULE_07: completed character sets pending, enters FIFO
// RULE_08: pending flag stays while FIFO holds data
// RULE_09: interrupt when received and enabled
// RULE_10: slave disables clock driver, uses pin clock
// RULE_11: data changes on leading edge, one bit/cycle
// RULE_12: external master sends only character-length clocks
// RULE_13: third character sets overrun, FIFO kept, blocked
// RULE_14: overrun clears by read or continuous clear; here a read clears it only while continuous receive is off
// RULE_15: port disable resets logic and overrun
// RULE_16: nine-bit option shifts nine; ninth readable
// RULE_17: software reads ninth bit before data
// RULE_18: software keeps address detect cleared
// RULE_19: mode from clock source and receive enables
// RULE_20: transmit enable; holding write starts transmission
// RULE_21: software loads ninth bit before holding write
// RULE_22: second word held, empty flag clear meanwhile
// RULE_23: holding waits until shifter finishes last bit
// RULE_24: master clock period from divisor and speed
`timescale 1ns/1ps
module ssp_top
   import ssp_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic data_line_pin_i,
   output logic data_line_pin_o,
   output logic data_line_pin_oe_n_o,
   input wire logic clock_line_pin_i,
   output logic clock_line_pin_o,
   output logic clock_line_pin_oe_n_o,
   output logic irq_o
);

   // bus group
   logic wreq_ff, nxt_wreq;
   logic [31:0] rdata_ff, nxt_rdata;
   // port group
   ssp_rx_ctrl_t rxc_ff, nxt_rxc;
   ssp_tx_ctrl_t txc_ff, nxt_txc;
   ssp_int_bits_t ien_ff, nxt_ien;
   logic [7:0] div_ff, nxt_div;
   logic [7:0] hold_ff, nxt_hold;
   logic hold_full_ff, nxt_hold_full;
   logic [8:0] tsr_ff, nxt_tsr;
   logic tsr_full_ff, nxt_tsr_full;
   logic [8:0] rsr_ff, nxt_rsr;
   logic [3:0] bit_ff, nxt_bit;
   ssp_mode_t mode_ff, nxt_mode;
   logic [8:0] fifo_ff [0:1];
   logic [8:0] nxt_fifo [0:1];
   logic [1:0] fcnt_ff, nxt_fcnt;
   logic overrun_flag_ff, nxt_overrun_flag;
   logic [10:0] tmr_ff, nxt_tmr;
   logic ck_ff, nxt_ck;
   logic dout_ff, nxt_dout;
   logic dt_oe_n_ff, nxt_dt_oe_n;
   logic ck_oe_n_ff, nxt_ck_oe_n;
   logic irq_ff, nxt_irq;
   logic ck_s1_ff, ck_s2_ff, ck_s3_ff;
   logic dt_s1_ff, dt_s2_ff;

   // shared decode
   logic wr_go, rd_go;
   logic active, rx_want, tx_mode, run, lead, trail;
   logic pop, receive_pending_flag, transmit_empty_flag, continuous_receive_enable_drop;
   ssp_rx_ctrl_t wr_rxc;
   ssp_mode_t want;
   logic [8:0] rx_char;

   assign wr_go = avs_write_i & ~wreq_ff & avs_byteenable_i[`SSP_LOW_BYTE_LANE];
   assign rd_go = avs_read_i & ~wreq_ff;
   assign wr_rxc = ssp_rx_ctrl_t'(avs_writedata_i[7:0]);
   assign pop = rd_go & (avs_address_i == `SSP_OFS_RX_DATA) & (fcnt_ff != 2'h0);
   assign continuous_receive_enable_drop = wr_go & (avs_address_i == `SSP_OFS_RX_CTRL)
                      & rxc_ff.continuous_receive_enable & ~wr_rxc.continuous_receive_enable;
   assign active = rxc_ff.port_enable & txc_ff.sync_mode; // RULE_19
   assign rx_want = active & (rxc_ff.single_receive_enable | rxc_ff.continuous_receive_enable)
                    & ~overrun_flag_ff; // RULE_02 RULE_13
   assign tx_mode = active & txc_ff.transmit_enable
                    & ~(rxc_ff.single_receive_enable | rxc_ff.continuous_receive_enable); // RULE_19 RULE_20
   assign receive_pending_flag = (fcnt_ff != 2'h0); // RULE_08
   assign transmit_empty_flag = active & txc_ff.transmit_enable & ~hold_full_ff; // RULE_22
   assign run = txc_ff.clock_source_master & (rx_want | (tx_mode & tsr_full_ff));
   assign want = rx_want ? SSP_RX : ((tx_mode & tsr_full_ff) ? SSP_TX : SSP_IDLE);

   // bus answer: waitrequest drops one cycle after the request appears
   always_comb
   begin
      nxt_wreq = ~((avs_read_i | avs_write_i) & wreq_ff);
      nxt_rdata = rdata_ff;
      if (avs_read_i & wreq_ff)
      begin
         nxt_rdata = 32'h0000_0000;
         unique case (avs_address_i)
            `SSP_OFS_RX_CTRL:
            begin
               nxt_rdata[7:0] = {rxc_ff.port_enable, rxc_ff.receive_nine_bit,
                                 rxc_ff.single_receive_enable, rxc_ff.continuous_receive_enable,
                                 rxc_ff.address_detect_enable, 1'b0, overrun_flag_ff, fifo_ff[0][8]}; // RULE_16
            end
            `SSP_OFS_TX_CTRL:
            begin
               nxt_rdata[7:0] = {txc_ff.clock_source_master, txc_ff.transmit_nine_bit,
                                 txc_ff.transmit_enable, txc_ff.sync_mode, 1'b0,
                                 txc_ff.baud_high_speed, ~tsr_full_ff, txc_ff.transmit_ninth_bit_value};
            end
            `SSP_OFS_BAUD_DIV: nxt_rdata[7:0] = div_ff;
            `SSP_OFS_RX_DATA: nxt_rdata[7:0] = fifo_ff[0][7:0]; // RULE_07
            `SSP_OFS_INT_EN: nxt_rdata[7:0] = ien_ff;
            `SSP_OFS_INT_FLAGS: nxt_rdata[7:0] = {2'h0, receive_pending_flag, transmit_empty_flag, 4'h0};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         wreq_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         wreq_ff <= nxt_wreq;
         rdata_ff <= nxt_rdata;
      end
   end

   // serial engine, control registers and pin drive
   always_comb
   begin
      nxt_rxc = rxc_ff;
      nxt_txc = txc_ff;
      nxt_ien = ien_ff;
      nxt_div = div_ff;
      nxt_hold = hold_ff;
      nxt_hold_full = hold_full_ff;
      nxt_tsr = tsr_ff;
      nxt_tsr_full = tsr_full_ff;
      nxt_rsr = rsr_ff;
      nxt_bit = bit_ff;
      nxt_mode = want;
      nxt_fifo = fifo_ff;
      nxt_fcnt = fcnt_ff;
      nxt_overrun_flag = overrun_flag_ff;
      nxt_tmr = tmr_ff;
      nxt_ck = ck_ff;
      nxt_dout = dout_ff;
      lead = 1'b0;
      trail = 1'b0;
      rx_char = 9'h000;

      // shift clock: own baud timer as master, pin edges as slave
      if (txc_ff.clock_source_master)
      begin
         if (run && want == mode_ff)
         begin
            if (tmr_ff + 11'h001 >= ssp_half_len(div_ff, txc_ff.baud_high_speed)) // RULE_24
            begin
               nxt_tmr = 11'h000;
               nxt_ck = ~ck_ff;
               lead = ~ck_ff;
               trail = ck_ff;
            end
            else
            begin
               nxt_tmr = tmr_ff + 11'h001;
            end
         end
         else
         begin
            nxt_tmr = 11'h000;
            nxt_ck = 1'b0; // RULE_04
         end
      end
      else
      begin
         nxt_tmr = 11'h000;
         nxt_ck = 1'b0;
         lead = ck_s2_ff & ~ck_s3_ff; // RULE_10
         trail = ~ck_s2_ff & ck_s3_ff; // RULE_10
      end

      // mode change drops any partial character
      if (want != mode_ff)
      begin
         nxt_bit = 4'h0; // RULE_04
      end
      else if (mode_ff == SSP_TX)
      begin
         if (lead)
         begin
            nxt_dout = tsr_ff[bit_ff]; // RULE_11
         end
         if (trail)
         begin
            if (bit_ff + 4'h1 == ssp_char_bits(txc_ff.transmit_nine_bit))
            begin
               nxt_bit = 4'h0;
               nxt_tsr_full = 1'b0; // RULE_23
            end
            else
            begin
               nxt_bit = bit_ff + 4'h1; // RULE_11
            end
         end
      end
      else if (mode_ff == SSP_RX && trail)
      begin
         nxt_rsr[bit_ff] = dt_s2_ff; // RULE_06
         if (bit_ff + 4'h1 == ssp_char_bits(rxc_ff.receive_nine_bit)) // RULE_16 RULE_12
         begin
            nxt_bit = 4'h0;
            rx_char = {rxc_ff.receive_nine_bit & nxt_rsr[8], nxt_rsr[7:0]};
            nxt_rxc.single_receive_enable = 1'b0; // RULE_03 RULE_05
         end
         else
         begin
            nxt_bit = bit_ff + 4'h1;
         end
      end

      // receive fifo
      if (pop)
      begin
         nxt_fifo[0] = fifo_ff[1];
         nxt_fcnt = fcnt_ff - 2'h1;
      end
      if (mode_ff == SSP_RX && want == SSP_RX && trail && nxt_bit == 4'h0)
      begin
         if (nxt_fcnt == `SSP_FIFO_DEPTH)
         begin
            nxt_overrun_flag = 1'b1; // RULE_13
         end
         else
         begin
            nxt_fifo[nxt_fcnt[0]] = rx_char; // RULE_07
            nxt_fcnt = nxt_fcnt + 2'h1;
         end
      end
      else if ((pop & ~rxc_ff.continuous_receive_enable) | continuous_receive_enable_drop)
      begin
         nxt_overrun_flag = 1'b0; // RULE_14
      end

      // holding register to shifter
      if (tx_mode & ~tsr_full_ff & hold_full_ff)
      begin
         nxt_tsr = {txc_ff.transmit_ninth_bit_value, hold_ff}; // RULE_21 RULE_23
         nxt_tsr_full = 1'b1;
         nxt_hold_full = 1'b0; // RULE_22
      end
      if (~tx_mode)
      begin
         nxt_tsr_full = 1'b0;
      end

      // register writes
      if (wr_go)
      begin
         unique case (avs_address_i)
            `SSP_OFS_RX_CTRL: nxt_rxc = wr_rxc;
            `SSP_OFS_TX_CTRL: nxt_txc = ssp_tx_ctrl_t'(avs_writedata_i[7:0]);
            `SSP_OFS_BAUD_DIV: nxt_div = avs_writedata_i[7:0];
            `SSP_OFS_TX_HOLD:
            begin
               nxt_hold = avs_writedata_i[7:0];
               nxt_hold_full = 1'b1; // RULE_20
            end
            `SSP_OFS_INT_EN: nxt_ien = ssp_int_bits_t'(avs_writedata_i[7:0]);
            default: nxt_rxc = nxt_rxc;
         endcase
      end

      // port disable clears the serial logic
      if (~rxc_ff.port_enable)
      begin
         nxt_hold_full = 1'b0; // RULE_15
         nxt_tsr_full = 1'b0;
         nxt_bit = 4'h0;
         nxt_fcnt = 2'h0;
         nxt_overrun_flag = 1'b0; // RULE_15
      end

      nxt_dt_oe_n = ~tx_mode; // RULE_01
      nxt_ck_oe_n = ~(active & txc_ff.clock_source_master); // RULE_10
      nxt_irq = (receive_pending_flag & ien_ff.receive) | (transmit_empty_flag & ien_ff.transmit); // RULE_09
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         rxc_ff <= ssp_rx_ctrl_t'(`SSP_RX_CTRL_RESET);
         txc_ff <= ssp_tx_ctrl_t'(`SSP_TX_CTRL_RESET);
         ien_ff <= ssp_int_bits_t'(`SSP_INT_EN_RESET);
         div_ff <= `SSP_BAUD_DIV_RESET;
         hold_ff <= `SSP_TX_HOLD_RESET;
         hold_full_ff <= 1'b0;
         tsr_ff <= 9'h000;
         tsr_full_ff <= 1'b0;
         rsr_ff <= 9'h000;
         bit_ff <= 4'h0;
         mode_ff <= SSP_IDLE;
         fifo_ff[0] <= 9'h000;
         fifo_ff[1] <= 9'h000;
         fcnt_ff <= 2'h0;
         overrun_flag_ff <= 1'b0;
         tmr_ff <= 11'h000;
         ck_ff <= 1'b0;
         dout_ff <= 1'b0;
         dt_oe_n_ff <= 1'b1;
         ck_oe_n_ff <= 1'b1;
         irq_ff <= 1'b0;
         ck_s1_ff <= 1'b0;
         ck_s2_ff <= 1'b0;
         ck_s3_ff <= 1'b0;
         dt_s1_ff <= 1'b0;
         dt_s2_ff <= 1'b0;
      end
      else
      begin
         rxc_ff <= nxt_rxc;
         txc_ff <= nxt_txc;
         ien_ff <= nxt_ien;
         div_ff <= nxt_div;
         hold_ff <= nxt_hold;
         hold_full_ff <= nxt_hold_full;
         tsr_ff <= nxt_tsr;
         tsr_full_ff <= nxt_tsr_full;
         rsr_ff <= nxt_rsr;
         bit_ff <= nxt_bit;
         mode_ff <= nxt_mode;
         fifo_ff <= nxt_fifo;
         fcnt_ff <= nxt_fcnt;
         overrun_flag_ff <= nxt_overrun_flag;
         tmr_ff <= nxt_tmr;
         ck_ff <= nxt_ck;
         dout_ff <= nxt_dout;
         dt_oe_n_ff <= nxt_dt_oe_n;
         ck_oe_n_ff <= nxt_ck_oe_n;
         irq_ff <= nxt_irq;
         ck_s1_ff <= clock_line_pin_i;
         ck_s2_ff <= ck_s1_ff;
         ck_s3_ff <= ck_s2_ff;
         dt_s1_ff <= data_line_pin_i;
         dt_s2_ff <= dt_s1_ff;
      end
   end

   assign avs_readdata_o = rdata_ff;
   assign avs_waitrequest_o = wreq_ff;
   assign data_line_pin_o = dout_ff;
   assign data_line_pin_oe_n_o = dt_oe_n_ff;
   assign clock_line_pin_o = ck_ff;
   assign clock_line_pin_oe_n_o = ck_oe_n_ff;
   assign irq_o = irq_ff;

endmodule : ssp_top

// ==== testbench/ssp_top_assertions.sv ====
// concurrent checks on the ports of the serial port top
`timescale 1ns/1ps
module ssp_top_assertions (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic data_line_pin_i,
   input wire logic data_line_pin_o,
   input wire logic data_line_pin_oe_n_o,
   input wire logic clock_line_pin_i,
   input wire logic clock_line_pin_o,
   input wire logic clock_line_pin_oe_n_o,
   input wire logic irq_o
);
   logic [7:0] div_ff, nxt_div;
   logic fast_ff, nxt_fast;
   logic [10:0] hi_ff, nxt_hi, half;
   logic acc;
   assign acc = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign half = fast_ff ? {3'h0, div_ff} + 11'h001 : ({3'h0, div_ff} + 11'h001) << 2;
   // divisor and speed as software set them
   always_comb
   begin
      nxt_div = (acc && avs_address_i == 5'h08) ? avs_writedata_i[7:0] : div_ff;
      nxt_fast = (acc && avs_address_i == 5'h04) ? avs_writedata_i[2] : fast_ff;
      nxt_hi = clock_line_pin_o ? hi_ff + 11'h001 : 11'h000;
   end
   always_ff @(posedge clk_sys_i)
   begin
      div_ff <= reset_i ? 8'h00 : nxt_div;
      fast_ff <= reset_i ? 1'b0 : nxt_fast;
      hi_ff <= reset_i ? 11'h000 : nxt_hi;
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait cycle");
   wait_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   idle_wait_a: assert property (!avs_read_i && !avs_write_i |-> avs_waitrequest_o)
      else $error("waitrequest low without request");
   read_pad_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   reset_safe_a: assert property ($fell(reset_i) |-> avs_waitrequest_o && data_line_pin_oe_n_o && clock_line_pin_oe_n_o && !irq_o)
      else $error("outputs not quiet after reset");
   half_period_a: assert property (!clock_line_pin_oe_n_o && $fell(clock_line_pin_o) |-> hi_ff == half)
      else $error("master clock high time wrong");
   lead_change_a: assert property (!clock_line_pin_oe_n_o && !data_line_pin_oe_n_o && !$past(data_line_pin_oe_n_o)
      && $changed(data_line_pin_o) |-> $rose(clock_line_pin_o))
      else $error("data changed away from leading edge");
   trail_stable_a: assert property (!data_line_pin_oe_n_o && $fell(clock_line_pin_o) |-> $stable(data_line_pin_o))
      else $error("data moved at trailing edge");
   clock_fall_c: cover property ($fell(clock_line_pin_o));
   read_done_c: cover property (avs_read_i && !avs_waitrequest_o);
   irq_rise_c: cover property ($rose(irq_o));
endmodule : ssp_top_assertions
bind ssp_top ssp_top_assertions chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .data_line_pin_i(data_line_pin_i), .data_line_pin_o(data_line_pin_o), .data_line_pin_oe_n_o(data_line_pin_oe_n_o),
   .clock_line_pin_i(clock_line_pin_i), .clock_line_pin_o(clock_line_pin_o),
   .clock_line_pin_oe_n_o(clock_line_pin_oe_n_o), .irq_o(irq_o));

// ==== testbench/ssp_far_end.sv ====
// far-end serial device: sends on leading edges, captures on trailing edges
`timescale 1ns/1ps
module ssp_far_end (
   input wire logic clock_line_i,
   input wire logic data_line_i,
   output logic far_clk_o,
   output logic far_data_o
);
   logic [8:0] word = 9'h000;
   int nbits = 8;
   int idx = 0;
   int fall_cnt = 0;
   logic [15:0] cap = 16'h0000;
   initial
   begin
      far_clk_o = 1'b0;
      far_data_o = 1'b0;
   end
   task automatic load(input logic [8:0] w, input int n);
      word = w;
      nbits = n;
      idx = 0;
      fall_cnt = 0;
   endtask : load
   always @(posedge clock_line_i)
   begin
      far_data_o <= word[idx];
      idx <= (idx == nbits - 1) ? 0 : idx + 1;
   end
   always @(negedge clock_line_i)
   begin
      cap <= {data_line_i, cap[15:1]};
      fall_cnt <= fall_cnt + 1;
   end
   // clock stands low outside frames
   task automatic frame(input int n);
      #7;
      repeat (n)
      begin
         #160 far_clk_o = 1'b1;
         #160 far_clk_o = 1'b0;
      end
   endtask : frame
endmodule : ssp_far_end

// ==== testbench/ssp_top_test.sv ====
// self-checking bench of the synchronous serial port
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_top_test;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, data_line_pin_o, data_line_pin_oe_n_o, clock_line_pin_o, clock_line_pin_oe_n_o, irq_o;
   logic far_clk, far_data, data_line, clock_line;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   assign data_line = data_line_pin_oe_n_o ? far_data : data_line_pin_o;
   assign clock_line = clock_line_pin_oe_n_o ? far_clk : clock_line_pin_o;
   ssp_top uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .data_line_pin_i(data_line),
      .data_line_pin_o(data_line_pin_o), .data_line_pin_oe_n_o(data_line_pin_oe_n_o), .clock_line_pin_i(clock_line),
      .clock_line_pin_o(clock_line_pin_o), .clock_line_pin_oe_n_o(clock_line_pin_oe_n_o), .irq_o(irq_o));
   ssp_far_end far (.clock_line_i(clock_line), .data_line_i(data_line), .far_clk_o(far_clk), .far_data_o(far_data));
   always #20 clk_sys_i = ~clk_sys_i;
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         end_sim();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask : check
   task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
      output logic [31:0] q);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_read_i <= rd;
      avs_write_i <= !rd;
      avs_writedata_i <= {24'h0, d};
      avs_byteenable_i <= be;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, 4'h1, q);
   endtask : wr
   task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b1, a, 8'h00, 4'hF, q);
      check(name, q, exp);
   endtask : rd_chk
   task automatic wait_reg(input logic [4:0] a, input logic [7:0] m);
      logic [31:0] q;
      int k;
      k = 0;
      do
      begin
         bus(1'b1, a, 8'h00, 4'hF, q);
         k++;
      end
      while ((q[7:0] & m) !== m && k < 500);
   endtask : wait_reg
   task automatic wait_falls(input int n);
      int k;
      k = 0;
      while (far.fall_cnt < n && k < 3000)
      begin
         @(posedge clk_sys_i);
         k++;
      end
   endtask : wait_falls
   task automatic t_reset;
      logic [31:0] q;
      for (int i = 0; i < 8; i++)
         rd_chk("reset value", 5'(i * 4), (i == 1) ? 32'h2 : 32'h0);
      bus(1'b0, `SSP_OFS_BAUD_DIV, 8'h55, 4'h0, q);
      wr(5'h1C, 8'hFF);
      rd_chk("masked write", `SSP_OFS_BAUD_DIV, 32'h0);
      rd_chk("unmapped", 5'h1C, 32'h0);
   endtask : t_reset
   task automatic t_master_tx;
      wr(`SSP_OFS_BAUD_DIV, 8'h01);
      wr(`SSP_OFS_TX_CTRL, 8'hB4);
      wr(`SSP_OFS_RX_CTRL, 8'h80);
      far.load(9'h000, 8);
      wr(`SSP_OFS_TX_HOLD, 8'hA5);
      wr(`SSP_OFS_TX_HOLD, 8'h3C);
      rd_chk("flags held", `SSP_OFS_INT_FLAGS, 32'h0);
      check("drivers", {30'h0, data_line_pin_oe_n_o, clock_line_pin_oe_n_o}, 32'h0);
      wait_falls(16);
      repeat (20) @(posedge clk_sys_i);
      check("tx bits", {16'h0, far.cap}, 32'h3CA5);
      rd_chk("flags empty", `SSP_OFS_INT_FLAGS, 32'h10);
      rd_chk("tx ctrl", `SSP_OFS_TX_CTRL, 32'hB6);
   endtask : t_master_tx
   task automatic t_master_rx;
      wr(`SSP_OFS_TX_CTRL, 8'h90);
      far.load(9'h15A, 9);
      wr(`SSP_OFS_RX_CTRL, 8'hE0);
      check("data drive", {31'h0, data_line_pin_oe_n_o}, 32'h1);
      wait_reg(`SSP_OFS_INT_FLAGS, 8'h20);
      repeat (200) @(posedge clk_sys_i);
      check("clocks", 32'(far.fall_cnt), 32'h9);
      rd_chk("rx ctrl", `SSP_OFS_RX_CTRL, 32'hC1);
      rd_chk("rx data", `SSP_OFS_RX_DATA, 32'h5A);
      rd_chk("flags", `SSP_OFS_INT_FLAGS, 32'h0);
   endtask : t_master_rx
   task automatic t_continuous;
      int k;
      int n;
      wr(`SSP_OFS_RX_CTRL, 8'h80);
      wr(`SSP_OFS_INT_EN, 8'h20);
      far.load(9'h0C3, 8);
      wr(`SSP_OFS_RX_CTRL, 8'hB0);
      k = 0;
      while (irq_o !== 1'b1 && k < 2000)
      begin
         @(posedge clk_sys_i);
         k++;
      end
      check("irq", {31'h0, irq_o}, 32'h1);
      rd_chk("both set", `SSP_OFS_RX_CTRL, 32'h90);
      wait_reg(`SSP_OFS_RX_CTRL, 8'h02);
      repeat (300) @(posedge clk_sys_i);
      check("clocks", 32'(far.fall_cnt), 32'h18);
      rd_chk("rx data", `SSP_OFS_RX_DATA, 32'hC3);
      rd_chk("flags", `SSP_OFS_INT_FLAGS, 32'h20);
      rd_chk("overrun", `SSP_OFS_RX_CTRL, 32'h92);
      rd_chk("rx data", `SSP_OFS_RX_DATA, 32'hC3);
      rd_chk("flags", `SSP_OFS_INT_FLAGS, 32'h0);
      wr(`SSP_OFS_RX_CTRL, 8'h80);
      rd_chk("overrun clr", `SSP_OFS_RX_CTRL, 32'h80);
      far.load(9'h0C3, 8);
      wr(`SSP_OFS_RX_CTRL, 8'h90);
      wait_reg(`SSP_OFS_RX_CTRL, 8'h02);
      wr(`SSP_OFS_RX_CTRL, 8'h10);
      rd_chk("port off", `SSP_OFS_RX_CTRL, 32'h10);
      rd_chk("fifo clr", `SSP_OFS_INT_FLAGS, 32'h0);
      far.load(9'h0C3, 8);
      wr(`SSP_OFS_RX_CTRL, 8'h90);
      wait_falls(4);
      wr(`SSP_OFS_RX_CTRL, 8'h80);
      n = far.fall_cnt;
      repeat (100) @(posedge clk_sys_i);
      check("abort", 32'(far.fall_cnt), 32'(n));
      rd_chk("partial", `SSP_OFS_INT_FLAGS, 32'h0);
   endtask : t_continuous
   task automatic t_slave_tx;
      wr(`SSP_OFS_TX_CTRL, 8'h71);
      repeat (2) @(posedge clk_sys_i);
      check("clk drive", {31'h0, clock_line_pin_oe_n_o}, 32'h1);
      far.load(9'h000, 8);
      wr(`SSP_OFS_TX_HOLD, 8'h96);
      wr(`SSP_OFS_TX_CTRL, 8'h70);
      wr(`SSP_OFS_TX_HOLD, 8'h69);
      rd_chk("held", `SSP_OFS_INT_FLAGS, 32'h0);
      far.frame(9);
      repeat (10) @(posedge clk_sys_i);
      check("slave nine", {23'h0, far.cap[15:7]}, 32'h196);
      rd_chk("moved", `SSP_OFS_INT_FLAGS, 32'h10);
      far.frame(9);
      repeat (10) @(posedge clk_sys_i);
      check("slave bits", {23'h0, far.cap[15:7]}, 32'h069);
   endtask : t_slave_tx
   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_reset();
      t_master_tx();
      t_master_rx();
      t_continuous();
      t_slave_tx();
      end_sim();
   end
endmodule : ssp_top_test
